// >>> verilog/dfl_pkg.sv
package dfl_pkg;

  // Register byte offsets
  localparam logic [7:0] DFL_OFS_FAULT  = 8'h00;
  localparam logic [7:0] DFL_OFS_CONFIG = 8'h04;
  localparam logic [7:0] DFL_OFS_EVENT  = 8'h08;
  localparam logic [7:0] DFL_OFS_IRQ_ST = 8'h0C;
  localparam logic [7:0] DFL_OFS_IRQ_MK = 8'h10;
  localparam logic [7:0] DFL_OFS_SRC    = 8'h14;

  // Fault bit positions
  localparam int DFL_NSRC         = 9;
  localparam int DFL_B_CRC        = 0;
  localparam int DFL_B_SELFTEST   = 1;
  localparam int DFL_B_SHORT      = 2;
  localparam int DFL_B_DRV_TEMP   = 3;
  localparam int DFL_B_MOT_TEMP   = 4;
  localparam int DFL_B_OVER_V     = 5;
  localparam int DFL_B_UNDER_V    = 6;
  localparam int DFL_B_FEEDBACK   = 7;
  localparam int DFL_B_PHASING    = 8;
  localparam int DFL_B_EVT_FAULT  = 22;

  // Reset values and the fatal source mask
  localparam logic [8:0]  DFL_CONFIG_RST  = 9'h000;
  localparam logic [1:0]  DFL_IRQ_MK_RST  = 2'h0;
  localparam logic [8:0]  DFL_FATAL_MASK  = 9'h003;

  // Edges from reset release until synced sensor levels are valid
  localparam logic [1:0]  DFL_SETTLE_CYC  = 2'h2;

  // Short-circuit hold-off time
  localparam int DFL_CLK_HZ       = 40_000_000;
  localparam int DFL_SHORT_MS     = 100;
  localparam int DFL_SHORT_CYC    = DFL_CLK_HZ / 1000 * DFL_SHORT_MS;

  // Raw condition inputs from the drive sensors
  typedef struct packed {
    logic       phasing;
    logic       fb_disconnect;
    logic       fb_tolerance;
    logic       fb_overcurrent;
    logic       under_v;
    logic       over_v;
    logic       mot_temp;
    logic       drv_temp;
    logic       short_det;
    logic       selftest_fail;
    logic       crc_fail;
  } dfl_cond_t;

endpackage

// >>> verilog/dfl_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser, one per bit
module dfl_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage read only by second stage
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// >>> verilog/dfl_top.sv
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
module dfl_top #(
  parameter int SHORT_CYC = dfl_pkg::DFL_SHORT_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  input  wire dfl_pkg::dfl_cond_t cond,
  output logic                   outputs_enable,
  output logic                   fault_flag,
  output logic                   irq
);
  import dfl_pkg::*;

  localparam int NC = $bits(dfl_cond_t);

  dfl_cond_t          cs;
  logic [NC-1:0]      cs_bits;
  logic [8:0]         fault_r;
  logic [8:0]         config_r;
  logic [8:0]         src;
  logic [8:0]         src_d_r;
  logic [8:0]         rise;
  logic [8:0]         latch_set;
  logic [8:0]         clr_req;
  logic [1:0]         irq_st_r;
  logic [1:0]         irq_mk_r;
  logic [31:0]        short_cnt_r;
  logic               short_hold;
  logic [8:0]         fault_nxt;
  logic [8:0]         auto_src;
  logic [1:0]         settle_r;
  logic               settle_done;
  logic               auto_block;
  logic               acc;
  logic               wr;
  logic               rd;
  logic               addr_ok;
  logic [31:0]        rdata;
  logic               enable_nxt;

  // Sensor levels come from outside this clock domain
  dfl_sync #(
    .W (NC)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (cond),
    .q       (cs_bits)
  );
  assign cs = dfl_cond_t'(cs_bits);

  // Condition vector in fault bit order
  always_comb
  begin
    src                 = '0;
    src[DFL_B_CRC]      = cs.crc_fail;
    src[DFL_B_SELFTEST] = cs.selftest_fail;
    src[DFL_B_SHORT]    = cs.short_det;
    src[DFL_B_DRV_TEMP] = cs.drv_temp;
    src[DFL_B_MOT_TEMP] = cs.mot_temp;
    src[DFL_B_OVER_V]   = cs.over_v;
    src[DFL_B_UNDER_V]  = cs.under_v;
    src[DFL_B_FEEDBACK] = cs.fb_overcurrent | cs.fb_disconnect | cs.fb_tolerance;
    src[DFL_B_PHASING]  = cs.phasing;
  end

  // Edge history for interrupt events
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      src_d_r <= '0;
    else
      src_d_r <= src;
  end
  assign rise = src & ~src_d_r;

  // APB decode, zero wait states
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign addr_ok = (paddr == DFL_OFS_FAULT) || (paddr == DFL_OFS_CONFIG)
                || (paddr == DFL_OFS_EVENT) || (paddr == DFL_OFS_IRQ_ST)
                || (paddr == DFL_OFS_IRQ_MK) || (paddr == DFL_OFS_SRC);

  // Fatal bits always latch; others only when their config bit is set
  always_comb
  begin
    latch_set = src & (config_r | DFL_FATAL_MASK);
    clr_req   = '0;
    if (wr && paddr == DFL_OFS_FAULT)
      clr_req = pwdata[8:0] & ~DFL_FATAL_MASK;
  end

  // Next latched state; a new event beats a clear in the same cycle
  assign fault_nxt = (fault_r & ~clr_req) | latch_set;

  // Latched fault status
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      fault_r <= '0;
    else
      fault_r <= fault_nxt;
  end

  // Latch configuration
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      config_r <= DFL_CONFIG_RST;
    else if (wr && paddr == DFL_OFS_CONFIG)
      config_r <= pwdata[8:0];
  end

  // Non-latching short: hold-off reloads while the short is present, so the
  // full 100ms runs from its end and a lasting short never re-enables early
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      short_cnt_r <= '0;
    else if (src[DFL_B_SHORT] && !config_r[DFL_B_SHORT])
      short_cnt_r <= SHORT_CYC;
    else if (short_cnt_r != 32'h0000_0000)
      short_cnt_r <= short_cnt_r - 32'h0000_0001;
  end
  assign short_hold = (short_cnt_r != 32'h0000_0000);

  // A present source that does not latch blocks the stage; fatal ones always latch
  for (genvar i = 0; i < DFL_NSRC; i++)
  begin : g_auto
    assign auto_src[i] = src[i] & ~config_r[i] & ~DFL_FATAL_MASK[i];
  end
  assign auto_block = short_hold | (auto_src != 9'h000);

  // Synced levels reach src two edges after reset; stage stays off until then
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      settle_r <= 2'h0;
    else if (!settle_done)
      settle_r <= settle_r + 2'h1;
  end
  assign settle_done = (settle_r == DFL_SETTLE_CYC);

  // Any latched bit keeps power stage off, fatal ones forever
  assign enable_nxt = (fault_nxt == 9'h000) && !auto_block && settle_done;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      outputs_enable <= 1'b0;
      fault_flag     <= 1'b0;
    end
    else
    begin
      outputs_enable <= enable_nxt;
      fault_flag     <= (fault_nxt != 9'h000);
    end
  end

  // Interrupt status: bit0 new latched fault, bit1 auto disable; read clears
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_st_r <= '0;
    else
    begin
      // Read clears only what the reader saw, so late events survive
      if (rd && paddr == DFL_OFS_IRQ_ST)
        irq_st_r <= (irq_st_r & ~prdata[1:0])
                  | {(rise & ~latch_set) != 9'h000, (rise & latch_set) != 9'h000};
      else
        irq_st_r <= irq_st_r | {(rise & ~latch_set) != 9'h000, (rise & latch_set) != 9'h000};
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_mk_r <= DFL_IRQ_MK_RST;
    else if (wr && paddr == DFL_OFS_IRQ_MK)
      irq_mk_r <= pwdata[1:0];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= (irq_st_r & irq_mk_r) != 2'h0;
  end

  // Read mux
  always_comb
  begin
    rdata = '0;
    case (paddr)
      DFL_OFS_FAULT:  rdata[8:0] = fault_r;
      DFL_OFS_CONFIG: rdata[8:0] = config_r;
      DFL_OFS_EVENT:  rdata[DFL_B_EVT_FAULT] = fault_flag;
      DFL_OFS_IRQ_ST: rdata[1:0] = irq_st_r;
      DFL_OFS_IRQ_MK: rdata[1:0] = irq_mk_r;
      DFL_OFS_SRC:    rdata[8:0] = src;
      default:        rdata = '0;
    endcase
  end

  // Registered APB answer at the edge that ends the setup cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      prdata  <= (psel & ~penable) ? rdata : prdata;
      pslverr <= psel & ~penable & ~addr_ok;
    end
  end

endmodule

// >>> tb/dfl_props.sv
`timescale 1ns/1ps
module dfl_props #(
  parameter int SHORT_CYC = dfl_pkg::DFL_SHORT_CYC
) (
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire dfl_pkg::dfl_cond_t cond,
  input wire logic               outputs_enable,
  input wire logic               fault_flag,
  input wire logic               irq
);
  import dfl_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  int quiet_r;
  // Quiet cycles on all conditions; saturates so it never wraps
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      quiet_r <= 0;
    else if (|cond)
      quiet_r <= 0;
    else if (quiet_r < SHORT_CYC + 9)
      quiet_r <= quiet_r + 1;
  // Sync and latch take three edges, six gives slack
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("ready missing");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready too long");
  a_crc_flags: assert property (cond.crc_fail [*6] |-> fault_flag)
    else $error("crc not flagged");
  a_selftest_off: assert property (cond.selftest_fail [*6] |-> !outputs_enable)
    else $error("selftest enabled");
  a_short_off: assert property (cond.short_det [*6] |-> !outputs_enable)
    else $error("short enabled");
  a_feedback_off: assert property ((cond.fb_overcurrent || cond.fb_disconnect ||
    cond.fb_tolerance) [*6] |-> !outputs_enable)
    else $error("feedback enabled");
  a_flag_disables: assert property (fault_flag |-> !outputs_enable)
    else $error("enabled with fault");
  a_quiet_enables: assert property (quiet_r > SHORT_CYC + 8 && !fault_flag |->
    outputs_enable)
    else $error("no re-enable");
  cover property (pslverr);
  cover property ($rose(fault_flag));
  cover property (irq);
endmodule

bind dfl_top dfl_props #(.SHORT_CYC(SHORT_CYC)) u_props (.ref_clk(ref_clk), .rst(rst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .cond(cond),
  .outputs_enable(outputs_enable), .fault_flag(fault_flag), .irq(irq));

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dfl_pkg::*;
  logic        ref_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  dfl_cond_t   cond;
  logic        outputs_enable;
  logic        fault_flag;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          mismatches;
  int          compares;

  dfl_top #(.SHORT_CYC(20)) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cond(cond), .outputs_enable(outputs_enable),
    .fault_flag(fault_flag), .irq(irq));

  // Free-running 40 MHz clock
  initial
  begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
      begin
        mismatches++;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One APB transfer; held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic setc(input logic [10:0] v);
    @(posedge ref_clk);
    cond <= dfl_cond_t'(v);
  endtask

  task automatic pulse(input int k);
    setc(11'h1 << k);
    cyc(6);
    setc(11'h000);
    cyc(6);
  endtask

  task automatic t_regs();
    apb(0, DFL_OFS_CONFIG, 0);
    chk(rd, 0);
    apb(0, 8'h18, 0);
    chk(er, 1);
    chk(outputs_enable, 1);
  endtask

  // Every non-fatal source latched; clear by one-bits only
  task automatic t_latch();
    int fb;
    apb(1, DFL_OFS_CONFIG, 32'h0000_01FC);
    for (int k = 2; k < 11; k++)
    begin
      fb = (k < 8) ? k : ((k == 10) ? 8 : 7);
      pulse(k);
      chk(outputs_enable, 0);
      apb(0, DFL_OFS_EVENT, 0);
      chk(rd[22], 1);
      chk(fault_flag, 1);
      apb(1, DFL_OFS_FAULT, ~(32'h1 << fb));
      apb(0, DFL_OFS_FAULT, 0);
      chk(rd, 32'h1 << fb);
      apb(1, DFL_OFS_FAULT, 32'h1 << fb);
      cyc(3);
      chk(outputs_enable, 1);
      chk(fault_flag, 0);
    end
  endtask

  task automatic t_irq();
    chk(irq, 0);
    apb(1, DFL_OFS_IRQ_MK, 1);
    cyc(2);
    chk(irq, 1);
    apb(0, DFL_OFS_IRQ_ST, 0);
    chk(rd, 1);
    cyc(2);
    chk(irq, 0);
  endtask

  // Non-latching sources other than short drop enable only while present
  task automatic t_auto();
    int fb;
    apb(1, DFL_OFS_CONFIG, 0);
    for (int k = 3; k < 11; k++)
    begin
      fb = (k < 8) ? k : ((k == 10) ? 8 : 7);
      setc(11'h1 << k);
      cyc(6);
      chk(outputs_enable, 0);
      apb(0, DFL_OFS_SRC, 0);
      chk(rd, 32'h1 << fb);
      setc(11'h000);
      cyc(6);
      chk(outputs_enable, 1);
    end
    apb(0, DFL_OFS_FAULT, 0);
    chk(rd, 0);
  endtask

  task automatic t_short();
    setc(11'h004);
    cyc(3);
    setc(11'h000);
    cyc(10);
    chk(outputs_enable, 0);
    cyc(20);
    chk(outputs_enable, 1);
    // A short that outlasts the hold-off keeps the stage off until it ends
    setc(11'h004);
    cyc(30);
    chk(outputs_enable, 0);
    setc(11'h000);
    cyc(34);
    chk(outputs_enable, 1);
    apb(0, DFL_OFS_IRQ_ST, 0);
    chk(rd, 2);
  endtask

  // Fatal bits ignore clears, so this runs last
  task automatic t_fatal();
    for (int k = 0; k < 2; k++)
    begin
      pulse(k);
      apb(1, DFL_OFS_FAULT, 32'hFFFF_FFFF);
      apb(0, DFL_OFS_FAULT, 0);
      chk(rd, (32'h1 << (k + 1)) - 1);
      chk(outputs_enable, 0);
    end
    // Corrupt flash present across a second reset: stage never enables
    setc(11'h001);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    repeat (8)
    begin
      cyc(1);
      chk(outputs_enable, 0);
    end
    apb(0, DFL_OFS_FAULT, 0);
    chk(rd, 1);
  endtask

  task automatic wrap_up();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial
  begin
    cyc(6000);
    mismatches++;
    wrap_up();
  end

  initial
  begin
    rst = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    cond = '0;
    mismatches = 0;
    compares = 0;
    cyc(12);
    rst <= 0;
    t_regs();
    t_latch();
    t_irq();
    t_auto();
    t_short();
    t_fatal();
    wrap_up();
  end
endmodule
